// ### design/ubrg_map.vh
// ubrg_map.vh: register map, field positions, reset values and encodings
// for the serial receive-error status and baud rate generator block.
// assumes a plain Verilog-2005 flow; included by bare name.
`ifndef UBRG_MAP_VH
`define UBRG_MAP_VH

// ----------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------
`define UBRG_ADDR_W 16
`define UBRG_ADDR_RXBUF 16'hffa0
`define UBRG_ADDR_STATUS 16'hffa1
`define UBRG_ADDR_BAUD 16'hffa2

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define UBRG_STATUS_RST 8'h00
`define UBRG_BAUD_RST 7'h00
`define UBRG_ZERO8 8'h00

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define UBRG_BIT_PARITY 2
`define UBRG_BIT_FRAMING 1
`define UBRG_BIT_OVERRUN 0
`define UBRG_SRC_MSB 6
`define UBRG_SRC_LSB 4
`define UBRG_DIV_MSB 3
`define UBRG_DIV_LSB 0
`define UBRG_BAUD_MSB 6

// ----------------------------------------------------------------------
// divider and prescaler constants
// ----------------------------------------------------------------------
// half a bit is 16 + k source ticks; counter top is 15 + k
`define UBRG_DIV_BASE 5'h0f
`define UBRG_SRC_EXT 3'h0
`define UBRG_PRE_ONES 7'h7f

// ----------------------------------------------------------------------
// character length and parity type encodings
// ----------------------------------------------------------------------
`define UBRG_LAST_BIT8 3'h7
`define UBRG_LAST_BIT7 3'h6
`define UBRG_PAR_NONE 2'h0
`define UBRG_PAR_ZERO 2'h1
`define UBRG_PAR_ODD 2'h2
`define UBRG_PAR_EVEN 2'h3

`endif

// ### design/ubrg_fifo.v
// ubrg_fifo.v: small synchronous FIFO for received bytes.
// assumes one clock, asynchronous active-low reset, DEPTH a power of two.
`timescale 1ns/100ps
`default_nettype none

module ubrg_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk,
    input wire reset_n,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output reg out_valid,
    input wire out_ready,
    output reg [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wptr;
    reg [AW-1:0] rptr;
    reg [AW:0] cnt;
    wire push;
    wire pop_mem;

    // full when the array holds DEPTH words
    assign in_ready = (cnt != DEPTH[AW:0]);
    assign push = in_valid & in_ready;
    // refill the output register when it is empty or being taken
    assign pop_mem = (cnt != {(AW+1){1'b0}}) & (~out_valid | out_ready);

    // storage array, no reset needed
    always @(posedge clk) begin
        if (push) begin
            mem[wptr] <= in_data;
        end
    end

    // pointers, count and registered head word
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wptr <= {AW{1'b0}};
            rptr <= {AW{1'b0}};
            cnt <= {(AW+1){1'b0}};
            out_valid <= 1'b0;
            out_data <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                wptr <= wptr + 1'b1;
            end
            if (pop_mem) begin
                out_data <= mem[rptr];
                rptr <= rptr + 1'b1;
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
            if (push & ~pop_mem) begin
                cnt <= cnt + 1'b1;
            end else if (pop_mem & ~push) begin
                cnt <= cnt - 1'b1;
            end
        end
    end

endmodule // ubrg_fifo

`default_nettype wire

// ### design/ubrg_top.v
// ubrg_top.v: serial receiver with receive-error status register and
// baud rate generator (prescaler plus 5-bit divider).
// assumes a CPU-side memory access port on clk, mode bits driven by
// same-clock logic, and asynchronous pins for the line and ext clock.
`timescale 1ns/100ps
`default_nettype none
`include "ubrg_map.vh"

// Contract
// RQ1: status register is 8-bit read-only, cleared to zero by reset.
// RQ2: bit 2 flags parity mismatch against configured parity type; the zero parity type is never flagged here.
// RQ3: bit 1 flags a stop bit not sampled high.
// RQ4: receiver checks only the first stop bit, whatever stop length.
// RQ5: bit 0 flags a frame completed before previous byte was read; here only once the buffer (head plus 8 words) is full.
// RQ6: overrun repeats on every later frame until receive buffer read.
// RQ7: baud register is 8-bit read/write, cleared to zero by reset.
// RQ8: bits 6..4 pick ext clock pin (0) or main clock over 2^n.
// RQ9: bits 3..0 make 5-bit counter divide by 16+k; 15 prohibited.
// RQ10: bit rate is source frequency over 2^(n+1) times (k+16).
// RQ11: with ext pin as source its frequency replaces main clock.
// RQ12: software must not write baud register during communication.
// RQ13: software stops transfer before changing the serial mode.
// RQ14: completed frame moves byte to receive buffer, raises request; here an overrun frame's byte is dropped, request still raised.
// RQ15: after line falls wait half bit; still low means start bit.
// RQ16: unused status bits 7..3 and baud bit 7 read zero.
module ubrg_top #(
    parameter DATA_W = 8,
    parameter FIFO_DEPTH = 8,
    parameter FIFO_AW = 3
) (
    input wire clk,
    input wire reset_n,
    input wire [15:0] cpu_addr,
    input wire cpu_wr,
    input wire cpu_rd,
    input wire [7:0] cpu_wdata,
    output reg [7:0] cpu_rdata,
    input wire rx_enable,
    input wire char_len8,
    input wire [1:0] parity_mode,
    input wire receive_line,
    input wire external_serial_clock_pin,
    output reg rx_complete_req,
    output reg rx_data_avail
);

    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------

    // address match for the CPU port
    function addr_hit;
        input [15:0] addr;
        input [15:0] target;
        begin
            addr_hit = (addr == target);
        end
    endfunction

    // low n bits set: prescaler terminal pattern for main clock / 2^n
    function [6:0] src_mask;
        input [2:0] n;
        begin
            src_mask = ~(`UBRG_PRE_ONES << n);
        end
    endfunction

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_START = 5'h02;
    localparam [4:0] ST_DATA = 5'h04;
    localparam [4:0] ST_PARITY = 5'h08;
    localparam [4:0] ST_STOP = 5'h10;

    reg [4:0] state;
    reg rx_s1;
    reg rx_s2;
    reg ext_s1;
    reg ext_s2;
    reg ext_s3;
    reg [6:0] baud_rate_control;
    reg [6:0] pre_cnt;
    reg [4:0] div_cnt;
    reg phase;
    reg [2:0] bit_cnt;
    reg [7:0] shift_data;
    reg par_bit;
    reg parity_error_flag;
    reg framing_error_flag;
    reg overrun_error_flag;
    reg ovr_pending;
    reg push_valid;
    reg [7:0] push_data;

    wire [2:0] src_sel;
    wire [3:0] div_sel;
    wire [4:0] div_top;
    wire src_tick;
    wire half_tick;
    wire bit_tick;
    wire div_restart;
    wire wr_baud;
    wire rd_rxbuf;
    wire frame_done;
    wire overrun_now;
    wire ones_odd;
    wire parity_bad;
    wire [2:0] last_bit;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [7:0] fifo_out_data;

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------

    // two flops on the line and ext clock; third flop for edge detect
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
        end else begin
            rx_s1 <= receive_line;
            rx_s2 <= rx_s1;
            ext_s1 <= external_serial_clock_pin;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
        end
    end

    // ------------------------------------------------------------------
    // CPU port decode
    // ------------------------------------------------------------------

    // writes to the baud register; reads of the buffer pop it
    assign wr_baud = cpu_wr & addr_hit(cpu_addr, `UBRG_ADDR_BAUD);
    assign rd_rxbuf = cpu_rd & addr_hit(cpu_addr, `UBRG_ADDR_RXBUF);

    // RQ7: baud register storage
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            baud_rate_control <= `UBRG_BAUD_RST;
        end else if (wr_baud) begin
            // RQ16: top bit not stored
            baud_rate_control <= cpu_wdata[`UBRG_BAUD_MSB:0];
        end
    end

    // RQ1: registered read data, unmapped addresses read zero
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cpu_rdata <= `UBRG_ZERO8;
        end else if (cpu_rd) begin
            case (cpu_addr)
                `UBRG_ADDR_STATUS: begin
                    cpu_rdata <= `UBRG_ZERO8;
                    cpu_rdata[`UBRG_BIT_PARITY] <= parity_error_flag;
                    cpu_rdata[`UBRG_BIT_FRAMING] <= framing_error_flag;
                    cpu_rdata[`UBRG_BIT_OVERRUN] <= overrun_error_flag;
                end
                `UBRG_ADDR_BAUD: begin
                    // RQ16: bit 7 reads zero
                    cpu_rdata <= {1'b0, baud_rate_control};
                end
                `UBRG_ADDR_RXBUF: begin
                    cpu_rdata <= fifo_out_valid ? fifo_out_data : `UBRG_ZERO8;
                end
                default: begin
                    cpu_rdata <= `UBRG_ZERO8;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // baud rate generator
    // ------------------------------------------------------------------
    assign src_sel = baud_rate_control[`UBRG_SRC_MSB:`UBRG_SRC_LSB];
    assign div_sel = baud_rate_control[`UBRG_DIV_MSB:`UBRG_DIV_LSB];
    // RQ9: top count 15 + k gives division by 16 + k
    assign div_top = `UBRG_DIV_BASE + {1'b0, div_sel};

    // free-running prescaler on the main clock
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pre_cnt <= 7'h00;
        end else begin
            pre_cnt <= pre_cnt + 1'b1;
        end
    end

    // RQ8: source pick, ext pin rising edge or main clock / 2^n
    // RQ11: ext pin edge stands in for the main clock
    assign src_tick = (src_sel == `UBRG_SRC_EXT) ? (ext_s2 & ~ext_s3) :
        ((pre_cnt & src_mask(src_sel)) == src_mask(src_sel));

    // RQ9: 5-bit counter, one half-bit tick per 16 + k source ticks
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_cnt <= 5'h00;
        end else if (div_restart) begin
            div_cnt <= 5'h00;
        end else if (src_tick) begin
            div_cnt <= (div_cnt == div_top) ? 5'h00 : div_cnt + 1'b1;
        end
    end

    assign half_tick = src_tick & (div_cnt == div_top); // no feedback from restart

    // RQ10: a bit lasts two half-bit periods, hence 2^(n+1)(k+16)
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            phase <= 1'b0;
        end else if (div_restart) begin
            phase <= 1'b0;
        end else if (half_tick) begin
            phase <= ~phase;
        end
    end

    assign bit_tick = half_tick & phase;

    // ------------------------------------------------------------------
    // receive state machine
    // ------------------------------------------------------------------

    // RQ15: restart on low line when idle, and on start confirmation
    assign div_restart = rx_enable & ~rx_s2 &
        ((state == ST_IDLE) | ((state == ST_START) & half_tick));

    assign last_bit = char_len8 ? `UBRG_LAST_BIT8 : `UBRG_LAST_BIT7;
    // RQ4: completion on the first stop bit only
    assign frame_done = rx_enable & (state == ST_STOP) & bit_tick;

    // RQ2: parity over data plus parity bit
    assign ones_odd = ^{shift_data, par_bit};
    assign parity_bad = (parity_mode == `UBRG_PAR_EVEN) ? ones_odd :
        (parity_mode == `UBRG_PAR_ODD) ? ~ones_odd : 1'b0;

    // RQ5: overrun when the buffer cannot take the new byte
    // RQ6: or while an earlier overrun awaits a buffer read
    assign overrun_now = ovr_pending | ~fifo_in_ready;

    // frame sequencing; disabling the receiver stops it at once
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_IDLE;
            bit_cnt <= 3'h0;
            shift_data <= 8'h00;
            par_bit <= 1'b0;
        end else if (!rx_enable) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    // RQ15: low level begins start check
                    if (!rx_s2) begin
                        state <= ST_START;
                    end
                end
                ST_START: begin
                    // RQ15: confirm start at half bit
                    if (half_tick) begin
                        state <= rx_s2 ? ST_IDLE : ST_DATA;
                        bit_cnt <= 3'h0;
                        shift_data <= 8'h00;
                        par_bit <= 1'b0;
                    end
                end
                ST_DATA: begin
                    if (bit_tick) begin
                        shift_data[bit_cnt] <= rx_s2;
                        bit_cnt <= bit_cnt + 1'b1;
                        if (bit_cnt == last_bit) begin
                            state <= (parity_mode == `UBRG_PAR_NONE) ?
                                ST_STOP : ST_PARITY;
                        end
                    end
                end
                ST_PARITY: begin
                    if (bit_tick) begin
                        par_bit <= rx_s2;
                        state <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    // RQ4: second stop bit never examined
                    if (bit_tick) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // status flags and completion
    // ------------------------------------------------------------------

    // RQ1: flags hold the result of the last completed frame
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            parity_error_flag <= 1'b0;
            framing_error_flag <= 1'b0;
            overrun_error_flag <= 1'b0;
        end else if (frame_done) begin
            // RQ2: parity mismatch
            parity_error_flag <= parity_bad;
            // RQ3: stop bit sampled low
            framing_error_flag <= ~rx_s2;
            // RQ5: buffer full or earlier overrun not yet read
            overrun_error_flag <= overrun_now;
        end
    end

    // RQ6: overrun sticks until buffer read; new overrun wins over read
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ovr_pending <= 1'b0;
        end else if (frame_done & overrun_now) begin
            ovr_pending <= 1'b1;
        end else if (rd_rxbuf) begin
            ovr_pending <= 1'b0;
        end
    end

    // RQ14: byte to receive buffer and completion pulse
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            push_valid <= 1'b0;
            push_data <= 8'h00;
            rx_complete_req <= 1'b0;
            rx_data_avail <= 1'b0;
        end else begin
            push_valid <= frame_done & ~overrun_now;
            push_data <= shift_data;
            rx_complete_req <= frame_done;
            rx_data_avail <= fifo_out_valid;
        end
    end

    // ------------------------------------------------------------------
    // receive buffer
    // ------------------------------------------------------------------

    // head word is the receive buffer; a CPU read takes it
    ubrg_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_rx_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .in_valid(push_valid),
        .in_ready(fifo_in_ready),
        .in_data(push_data),
        .out_valid(fifo_out_valid),
        .out_ready(rd_rxbuf),
        .out_data(fifo_out_data)
    );

endmodule // ubrg_top

`default_nettype wire

// ### dv/ubrg_line_model.sv
// ubrg_line_model.sv: far-side serial transmitter driving the receive line.
// assumes the bench passes the bit length in clk cycles per frame.
`timescale 1ns/100ps
`default_nettype none

module ubrg_line_model (
    input wire logic clk,
    output logic line
);
    // -----------------------------------------------------------------
    // line driver
    // -----------------------------------------------------------------
    // idle line rests high
    initial line = 1'b1;

    // hold one level for a number of clocks
    task automatic put(input logic v, input int clks);
        line <= v;
        repeat (clks) @(posedge clk);
    endtask

    // one frame, lsb first, optional parity, single stop bit
    task automatic send(input logic [7:0] d, input logic len8, input logic [1:0] pm,
                        input logic flip, input logic stop, input int bc);
        int b;
        logic ones;
        ones = len8 ? ^d : ^d[6:0];
        @(posedge clk);
        put(1'b0, bc);
        for (b = 0; b < (len8 ? 8 : 7); b++) begin
            put(d[b], bc);
        end
        if (pm != 2'h0) begin
            put(((pm == 2'h1) ? 1'b0 : (pm == 2'h2) ? ~ones : ones) ^ flip, bc);
        end
        // one stop bit only, next frame may follow at once
        put(stop, stop ? bc : bc / 2 + 8);
        // cut stop bit: idle one bit so the false start it leaves dies out
        if (!stop) put(1'b1, bc);
        line <= 1'b1;
    endtask

    // short low pulse that is no start bit
    task automatic glitch(input int clks);
        @(posedge clk);
        put(1'b0, clks);
        line <= 1'b1;
    endtask
endmodule // ubrg_line_model

`default_nettype wire

// ### dv/ubrg_top_properties.sv
// ubrg_top_properties.sv: port checker for the receiver top.
// assumes it is bound to ubrg_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none

module ubrg_top_properties (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire logic [7:0] cpu_wdata,
    input wire logic [7:0] cpu_rdata,
    input wire logic rx_enable,
    input wire logic rx_complete_req,
    input wire logic rx_data_avail
);
    // -----------------------------------------------------------------
    // properties
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    property p_rst;
        $rose(reset_n) |-> cpu_rdata == 8'h00 && !rx_complete_req && !rx_data_avail;
    endproperty
    a_rst: assert property (p_rst)
        else $error("outputs not clear after reset");

    property p_req_pulse;
        rx_complete_req |=> !rx_complete_req;
    endproperty
    a_req_pulse: assert property (p_req_pulse)
        else $error("completion request longer than one cycle");

    property p_rdata_hold;
        !cpu_rd |=> $stable(cpu_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data changed without a read");

    property p_status_zero;
        cpu_rd && cpu_addr == 16'hffa1 |=> cpu_rdata[7:3] == 5'h00;
    endproperty
    a_status_zero: assert property (p_status_zero)
        else $error("unused status bits not zero");

    property p_baud_rw;
        cpu_wr && cpu_addr == 16'hffa2 ##1 !cpu_wr ##1 cpu_rd && cpu_addr == 16'hffa2
            |=> cpu_rdata == ($past(cpu_wdata, 3) & 8'h7f);
    endproperty
    a_baud_rw: assert property (p_baud_rw)
        else $error("baud readback differs from write");

    property p_unmapped;
        cpu_rd && !(cpu_addr inside {16'hffa0, 16'hffa1, 16'hffa2}) |=> cpu_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");

    property p_avail;
        rx_complete_req |-> ##[1:5] rx_data_avail;
    endproperty
    a_avail: assert property (p_avail)
        else $error("no byte available after completion");

    property p_abort;
        !rx_enable [*3] |-> !rx_complete_req;
    endproperty
    a_abort: assert property (p_abort)
        else $error("completion while receive disabled");
endmodule // ubrg_top_properties

bind ubrg_top ubrg_top_properties u_props (
    .clk(clk), .reset_n(reset_n), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .rx_enable(rx_enable), .rx_complete_req(rx_complete_req),
    .rx_data_avail(rx_data_avail)
);

`default_nettype wire

// ### dv/ubrg_top_test.sv
// ubrg_top_test.sv: self-checking bench for the receiver top.
// assumes the line model as far side and a free-running ext clock.
`timescale 1ns/100ps
`default_nettype none

module ubrg_top_test;
    // -----------------------------------------------------------------
    // signals and instances
    // -----------------------------------------------------------------
    logic clk = 1'b0, reset_n = 1'b0, cpu_wr = 1'b0, cpu_rd = 1'b0;
    logic rx_enable = 1'b0, char_len8 = 1'b1, ext_pin = 1'b0;
    logic [15:0] cpu_addr = 16'h0000;
    logic [7:0] cpu_wdata = 8'h00;
    logic [1:0] parity_mode = 2'h0;
    logic [47:0] r;
    wire line, req, avail;
    wire [7:0] rdata;
    int bad_count = 0, total_checks = 0, i;
    // baud, len8, parity, data, flip, stop, status, byte
    logic [47:0] rows [12] = '{
        48'h10_1_0_a5_0_1_00_a5, 48'h10_1_2_3c_0_1_00_3c, 48'h10_1_3_3d_1_1_04_3d,
        48'h10_1_1_ff_1_1_00_ff, 48'h10_0_2_ff_0_1_00_7f, 48'h10_1_0_81_0_0_02_81,
        48'h20_1_3_5a_0_1_00_5a, 48'h12_1_0_c3_0_1_00_c3, 48'h1e_1_2_96_0_1_00_96,
        48'h00_1_0_69_0_1_00_69, 48'h10_1_2_0f_1_1_04_0f, 48'h10_1_3_70_1_0_06_70};

    ubrg_top uut (
        .clk(clk), .reset_n(reset_n), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
        .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(rdata),
        .rx_enable(rx_enable), .char_len8(char_len8), .parity_mode(parity_mode),
        .receive_line(line), .external_serial_clock_pin(ext_pin),
        .rx_complete_req(req), .rx_data_avail(avail)
    );
    ubrg_line_model far (.clk(clk), .line(line));

    // 50 ns clock and ext clock of 8 clk periods, unrelated phase
    initial forever #25 clk = ~clk;
    initial begin
        #13;
        forever #200 ext_pin = ~ext_pin;
    end

    // -----------------------------------------------------------------
    // tasks
    // -----------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        cpu_addr <= a;
        cpu_wdata <= d;
        cpu_wr <= 1'b1;
        @(posedge clk);
        cpu_wr <= 1'b0;
    endtask

    task automatic rdchk(input string nm, input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        cpu_addr <= a;
        cpu_rd <= 1'b1;
        @(posedge clk);
        cpu_rd <= 1'b0;
        #1 chk(nm, e, rdata);
    endtask

    // bit length in clk: 2*(16+k) source ticks, ext tick is 8 clk
    function automatic int bc(input logic [7:0] b);
        return 2 * (16 + b[3:0]) * ((b[6:4] == 3'h0) ? 8 : (1 << b[6:4]));
    endfunction

    // send a frame and wait for its completion pulse
    task automatic frame(input logic [7:0] d, input logic flip, input logic stop, input int bt);
        int t;
        // receiver back on after any mode change
        @(posedge clk);
        rx_enable <= 1'b1;
        fork
            far.send(d, char_len8, parity_mode, flip, stop, bt);
            begin
                for (t = 0; t < 6000 && req !== 1'b1; t++) @(negedge clk);
                if (t == 6000) begin
                    chk("completion", 8'h01, 8'h00);
                    complete_run();
                end
            end
        join
    endtask

    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rx_enable <= 1'b1;
        rdchk("status", 16'hffa1, 8'h00);
        rdchk("baud", 16'hffa2, 8'h00);
        rdchk("unmapped", 16'hffa3, 8'h00);
        rdchk("empty_buf", 16'hffa0, 8'h00);
        wr(16'hffa1, 8'hff);
        rdchk("status_ro", 16'hffa1, 8'h00);
        wr(16'hffa2, 8'hff);
        rdchk("baud_bit7", 16'hffa2, 8'h7f);
        $display("test reset done");
        for (i = 0; i < 12; i++) begin
            r = rows[i];
            // baud changed while idle, mode while stopped
            wr(16'hffa2, r[47:40]);
            rx_enable <= 1'b0;
            char_len8 <= r[36];
            parity_mode <= r[33:32];
            rdchk("baud", 16'hffa2, r[47:40]);
            frame(r[31:24], r[20], r[16], bc(r[47:40]));
            rdchk("status", 16'hffa1, r[15:8]);
            rdchk("rx_byte", 16'hffa0, r[7:0]);
        end
        $display("test rows done");
        // fill buffer past nine bytes without reading
        wr(16'hffa2, 8'h10);
        rx_enable <= 1'b0;
        char_len8 <= 1'b1;
        parity_mode <= 2'h0;
        for (i = 0; i < 11; i++) begin
            frame(8'h10 + i[7:0], 1'b0, 1'b1, 64);
            rdchk("status", 16'hffa1, (i > 8) ? 8'h01 : 8'h00);
        end
        rdchk("rx_byte", 16'hffa0, 8'h10);
        frame(8'h1b, 1'b0, 1'b1, 64);
        rdchk("status", 16'hffa1, 8'h00);
        for (i = 1; i < 10; i++) begin
            rdchk("rx_byte", 16'hffa0, (i == 9) ? 8'h1b : 8'h10 + i[7:0]);
        end
        rdchk("empty_buf", 16'hffa0, 8'h00);
        chk("avail", 8'h00, {7'h00, avail});
        $display("test overrun done");
        // receive disabled mid-frame: nothing reported
        @(posedge clk);
        rx_enable <= 1'b0;
        parity_mode <= 2'h3; // mode changed while stopped
        fork
            far.send(8'h55, 1'b1, 2'h3, 1'b1, 1'b1, 64);
            begin
                @(posedge clk);
                rx_enable <= 1'b1;
                repeat (200) @(posedge clk);
                rx_enable <= 1'b0;
            end
        join
        rx_enable <= 1'b1;
        rdchk("status", 16'hffa1, 8'h00);
        chk("avail", 8'h00, {7'h00, avail});
        // low pulse shorter than half a bit
        far.glitch(10);
        for (i = 0; i < 800 && req !== 1'b1; i++) @(negedge clk);
        chk("false_start", 8'h00, {7'h00, req});
        $display("test abort done");
        complete_run();
    end
endmodule // ubrg_top_test

`default_nettype wire
